// ---- hdl/ccpu_top.v ----
// ccp unit: capture, compare and standard pwm for one channel, avalon-mm slave
// assumes synchronous inputs, one clock mclk, sync reset srst, cpu prefetch
// and adc live outside; time base is owned here (counts at a q-clock enable or an external tick)
//
// Overview of operation
// - on a capture event copy the full 16-bit time base into match pair
// - mode selects falling, rising, every 4th or every 16th rising edge
// - captures set event flag; only a software write clears it
// - a later capture overwrites the stored value, no overflow flag
// - 3-bit source select picks pin, comparators, pin change or four logic cells
// - capture sees actual pin level, so own port writes may capture
// - edge prescaler clears when disabled, not capturing, or reset
// - direct prescale change keeps counter; software clears control first
// - in sleep a q-clocked time base holds; external clock keeps capturing
// - compare match pair against time base and apply mode action
// - every compare match sets event flag and may start a conversion
// - writing control to zero forces compare output latch low
// - unit output is offered to other peripherals regardless of routing
// - flagged match with this unit as trigger source pulses conversion trigger
// - trigger match resets time base next edge unless match value changed
// - compare works in sleep only with running time base; flag wakes when event enable is set
// - pwm mode makes up to ten-bit duty waveform from period timer
// - pwm reaches the pin only while direction bit is cleared
// - duty zero stays low, full-scale duty stays high
// - after timer equals period: clear timer, set output unless zero, load duty
// - ten-bit base from 8-bit timer plus two low bits; clear output on duty
// - in sleep period timer and state freeze, output holds level
`timescale 1ns/1ps
`include "ccpu_map.vh"

module ccpu_top (
  // clock, reset, enable
  input  wire        mclk,
  input  wire        srst,
  input  wire        clk_en,
  // avalon-mm slave
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // capture sources
  input  wire        capture_pin_input_select,
  input  wire        comparator_one_synced,
  input  wire        comparator_two_synced,
  input  wire        pin_change_event,
  input  wire        logic_cell_one_output,
  input  wire        logic_cell_two_output,
  input  wire        logic_cell_three_output,
  input  wire        logic_cell_four_output,
  // system context
  input  wire        sleep_mode,
  input  wire        tb_ext_tick,
  input  wire        tb_ext_clocked,
  input  wire        trigger_source_sel,
  input  wire        pin_direction_bit,
  // outputs
  output reg         ccp_out,
  output reg         pin_out,
  output reg         pin_oe,
  output reg         ccp_event_flag,
  output reg         wake_req,
  output reg         conv_trigger
);

  // ************************************************************
  // registers and state
  // ************************************************************
  reg  [7:0]  ccp_control_register;
  reg  [2:0]  capture_source_select;
  reg  [7:0]  match_value_low;
  reg  [7:0]  match_value_high;
  reg         ccp_event_enable;
  reg  [7:0]  pwm_period_register;
  reg  [2:0]  period_timer_control;
  reg  [15:0] capture_time_base;
  reg  [7:0]  pwm_period_timer;
  reg  [3:0]  pt_pre_reg;
  reg  [9:0]  duty_buf_reg;
  reg  [3:0]  edge_cnt_reg;
  reg  [1:0]  qphase_reg;
  reg         src_s1_reg;
  reg         src_s2_reg;
  reg         src_prev_reg;
  reg         tb_rst_pend_reg;
  reg  [15:0] trig_match_reg;
  reg         ack_reg;

  wire        en      = ccp_control_register[`CCPU_CTRL_EN];
  wire [3:0]  mode    = ccp_control_register[`CCPU_CTRL_MODE];
  wire [15:0] match16 = {match_value_high, match_value_low};
  wire        is_cap  = en && (mode[3:2] == 2'b01);
  wire        is_pwm  = en && (mode == `CCPU_M_PWM);
  wire        is_cmp  = en && !is_cap && !is_pwm && (mode != `CCPU_M_OFF);
  // writes land at the edge where the master sees waitrequest low,
  // so a request that is still held then is never half applied
  wire        do_wr   = avs_write && ack_reg;
  wire        do_rd   = avs_read && !ack_reg;
  wire        frozen  = sleep_mode && !tb_ext_clocked;

  // source select mux
  reg src_mux;
  always @* begin
    case (capture_source_select)
      3'h0:    src_mux = capture_pin_input_select;
      3'h1:    src_mux = comparator_one_synced;
      3'h2:    src_mux = comparator_two_synced;
      3'h3:    src_mux = pin_change_event;
      3'h4:    src_mux = logic_cell_one_output;
      3'h5:    src_mux = logic_cell_two_output;
      3'h6:    src_mux = logic_cell_three_output;
      default: src_mux = logic_cell_four_output;
    endcase
  end

  // edge detection on the second synchroniser stage only
  wire rise = src_s2_reg && !src_prev_reg;
  wire fall = !src_s2_reg && src_prev_reg;
  reg  cap_evt;
  always @* begin
    cap_evt = 1'b0;
    if (is_cap && !frozen) begin
      case (mode)
        `CCPU_M_CAP_FALL: cap_evt = fall;
        `CCPU_M_CAP_RISE: cap_evt = rise;
        `CCPU_M_CAP_R4:   cap_evt = rise && (edge_cnt_reg[1:0] == `CCPU_PS4_LAST);
        `CCPU_M_CAP_R16:  cap_evt = rise && (edge_cnt_reg == `CCPU_PS16_LAST);
        default:          cap_evt = 1'b0;
      endcase
    end
  end

  // time base ticks on q-clock or external tick, never raw mclk
  wire tb_tick = tb_ext_clocked ? tb_ext_tick : (!sleep_mode && (qphase_reg == 2'h3));
  wire cmp_hit = is_cmp && (match16 == capture_time_base) && tb_tick;
  // every compare mode may start a conversion once this unit is the source
  wire trig    = cmp_hit && trigger_source_sel;

  // pwm tick: 10-bit base low bits from clock phase or prescaler
  wire [1:0] lo2      = (period_timer_control[`CCPU_PT_PS] == `CCPU_PS_1TO1) ? qphase_reg :
                        (period_timer_control[`CCPU_PT_PS] == `CCPU_PS_1TO4) ? pt_pre_reg[1:0] :
                        pt_pre_reg[3:2];
  wire [3:0] pre_last = (period_timer_control[`CCPU_PT_PS] == `CCPU_PS_1TO1) ? 4'h0 :
                        (period_timer_control[`CCPU_PT_PS] == `CCPU_PS_1TO4) ? `CCPU_PS4_LAST :
                        `CCPU_PS16_LAST;
  wire pt_run  = period_timer_control[`CCPU_PT_ON] && !sleep_mode;
  wire pt_inc  = pt_run && (qphase_reg == 2'h3) && (pt_pre_reg == pre_last);
  wire pt_wrap = pt_inc && (pwm_period_timer == pwm_period_register);
  wire [9:0] base10 = {pwm_period_timer, lo2};
  // the 10-bit base steps every mclk at 1:1, else when the bits below it roll;
  // the output drops on the step into the duty value, so it is high for
  // exactly duty base counts (a registered compare on base10 itself
  // would stretch every pulse by one base count)
  wire       base_step = pt_run && ((period_timer_control[`CCPU_PT_PS] == `CCPU_PS_1TO1) ||
                         ((qphase_reg == 2'h3) && ((period_timer_control[`CCPU_PT_PS] == `CCPU_PS_1TO4) ||
                          (pt_pre_reg[1:0] == 2'h3))));
  wire [9:0] base_next = base10 + `CCPU_ONE10;
  wire [9:0] duty_in = ccp_control_register[`CCPU_CTRL_FMT] ?
                       {match_value_high, match_value_low[7:6]} : {match_value_high[1:0], match_value_low};

  // ************************************************************
  // bus slave: one wait cycle, answer on second edge
  // ************************************************************
  always @(posedge mclk) begin
    if (srst) begin
      ack_reg         <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else if (clk_en) begin
      ack_reg         <= (avs_read || avs_write) && !ack_reg;
      avs_waitrequest <= !((avs_read || avs_write) && !ack_reg);
      if (do_rd) begin
        if (avs_address == `CCPU_OFF_CTRL)
          avs_readdata <= {24'h000000, en, 1'b0, ccp_out, ccp_control_register[4:0]};
        else if (avs_address == `CCPU_OFF_CAPSRC)
          avs_readdata <= {29'h0, capture_source_select};
        else if (avs_address == `CCPU_OFF_MATCH)
          avs_readdata <= {16'h0000, match16};
        else if (avs_address == `CCPU_OFF_FLAG)
          avs_readdata <= {30'h0, ccp_event_enable, ccp_event_flag};
        else if (avs_address == `CCPU_OFF_PER)
          avs_readdata <= {24'h000000, pwm_period_register};
        else if (avs_address == `CCPU_OFF_PTCTL)
          avs_readdata <= {29'h0, period_timer_control};
        else if (avs_address == `CCPU_OFF_TBASE)
          avs_readdata <= {16'h0000, capture_time_base};
        else if (avs_address == `CCPU_OFF_STAT)
          avs_readdata <= {22'h0, duty_buf_reg};
        else
          avs_readdata <= 32'h0000_0000; // unmapped reads zero
      end
    end
  end

  // ************************************************************
  // control registers, match pair, flag
  // ************************************************************
  always @(posedge mclk) begin
    if (srst) begin
      ccp_control_register  <= `CCPU_RST_BYTE;
      capture_source_select <= 3'h0;
      match_value_low       <= `CCPU_RST_BYTE;
      match_value_high      <= `CCPU_RST_BYTE;
      ccp_event_enable      <= 1'b0;
      ccp_event_flag        <= 1'b0;
      pwm_period_register   <= `CCPU_RST_BYTE;
      period_timer_control  <= 3'h0;
    end else if (clk_en) begin
      if (do_wr && avs_address == `CCPU_OFF_CTRL)
        ccp_control_register <= {avs_writedata[7], 2'b00, avs_writedata[4:0]}; // prescale kept
      if (do_wr && avs_address == `CCPU_OFF_CAPSRC)
        capture_source_select <= avs_writedata[2:0];
      if (do_wr && avs_address == `CCPU_OFF_PER)
        pwm_period_register <= avs_writedata[7:0];
      if (do_wr && avs_address == `CCPU_OFF_PTCTL)
        period_timer_control <= avs_writedata[2:0];
      // capture wins over a same-cycle software write
      if (cap_evt) begin
        match_value_low  <= capture_time_base[7:0];
        match_value_high <= capture_time_base[15:8];
      end else if (do_wr && avs_address == `CCPU_OFF_MATCH) begin
        match_value_low  <= avs_writedata[7:0];
        match_value_high <= avs_writedata[15:8];
      end
      if (do_wr && avs_address == `CCPU_OFF_FLAG)
        ccp_event_enable <= avs_writedata[1];
      // hardware set beats software clear
      if (cap_evt || cmp_hit)
        ccp_event_flag <= 1'b1;
      else if (do_wr && avs_address == `CCPU_OFF_FLAG)
        ccp_event_flag <= avs_writedata[0];
    end
  end

  // ************************************************************
  // synchroniser, edge prescaler, q-phase
  // ************************************************************
  always @(posedge mclk) begin
    if (srst) begin
      src_s1_reg   <= 1'b0;
      src_s2_reg   <= 1'b0;
      src_prev_reg <= 1'b0;
      edge_cnt_reg <= 4'h0;
      qphase_reg   <= 2'h0;
    end else if (clk_en) begin
      src_s1_reg   <= src_mux;
      src_s2_reg   <= src_s1_reg;
      src_prev_reg <= src_s2_reg;
      qphase_reg   <= qphase_reg + `CCPU_ONE2;
      if (!is_cap)
        edge_cnt_reg <= 4'h0;
      else if (rise && !frozen)
        edge_cnt_reg <= edge_cnt_reg + `CCPU_ONE4;
    end
  end

  // ************************************************************
  // capture time base with trigger reset
  // ************************************************************
  always @(posedge mclk) begin
    if (srst) begin
      capture_time_base <= 16'h0000;
      tb_rst_pend_reg   <= 1'b0;
      trig_match_reg    <= 16'h0000;
    end else if (clk_en) begin
      tb_rst_pend_reg <= trig;
      if (trig)
        trig_match_reg <= match16;
      // a changed match value cancels the pending reset
      if (tb_rst_pend_reg && (match16 == trig_match_reg))
        capture_time_base <= 16'h0000;
      else if (do_wr && avs_address == `CCPU_OFF_TBASE)
        capture_time_base <= avs_writedata[15:0];
      else if (tb_tick)
        capture_time_base <= capture_time_base + `CCPU_ONE16;
    end
  end

  // ************************************************************
  // compare latch, pwm and outputs
  // ************************************************************
  always @(posedge mclk) begin
    if (srst) begin
      pwm_period_timer <= 8'h00;
      pt_pre_reg       <= 4'h0;
      duty_buf_reg     <= `CCPU_ZERO10;
      ccp_out          <= 1'b0;
      pin_out          <= 1'b0;
      pin_oe           <= 1'b0;
      conv_trigger     <= 1'b0;
      wake_req         <= 1'b0;
    end else if (clk_en) begin
      conv_trigger <= trig;
      wake_req     <= ccp_event_flag && ccp_event_enable;
      if (pt_run && qphase_reg == 2'h3)
        pt_pre_reg <= (pt_pre_reg == pre_last) ? 4'h0 : pt_pre_reg + `CCPU_ONE4;
      if (pt_wrap)
        pwm_period_timer <= 8'h00;
      else if (pt_inc)
        pwm_period_timer <= pwm_period_timer + `CCPU_ONE8;
      if (do_wr && avs_address == `CCPU_OFF_CTRL && avs_writedata[7:0] == `CCPU_RST_BYTE)
        ccp_out <= 1'b0;
      else if (is_pwm && !sleep_mode) begin
        if (pt_wrap) begin
          duty_buf_reg <= duty_in;
          ccp_out      <= (duty_in != `CCPU_ZERO10);
        end else if (base_step && base_next == duty_buf_reg && duty_buf_reg != `CCPU_DUTY_FULL)
          ccp_out <= 1'b0;
      end else if (cmp_hit) begin
        case (mode)
          `CCPU_M_CMP_TGLR, `CCPU_M_CMP_TGL: ccp_out <= !ccp_out;
          `CCPU_M_CMP_SET:                   ccp_out <= 1'b1;
          `CCPU_M_CMP_CLR:                   ccp_out <= 1'b0;
          default:                           ccp_out <= ccp_out;
        endcase
      end
      pin_out <= ccp_out; // internal copy is ccp_out
      pin_oe  <= !pin_direction_bit;
    end
  end

endmodule // ccpu_top

// ---- include/ccpu_map.vh ----
// register map, field positions, mode codes and reset values for the ccp unit
// assumes inclusion by bare name from the design file
`ifndef CCPU_MAP_VH
`define CCPU_MAP_VH

// ************************************************************
// word offsets (word addresses, one 32-bit word each)
// ************************************************************
`define CCPU_OFF_CTRL   4'h0
`define CCPU_OFF_CAPSRC 4'h1
`define CCPU_OFF_MATCH  4'h2
`define CCPU_OFF_FLAG   4'h3
`define CCPU_OFF_PER    4'h4
`define CCPU_OFF_PTCTL  4'h5
`define CCPU_OFF_TBASE  4'h6
`define CCPU_OFF_STAT   4'h7

// ************************************************************
// control fields
// ************************************************************
`define CCPU_CTRL_EN    7
`define CCPU_CTRL_FMT   4
`define CCPU_CTRL_MODE  3:0
`define CCPU_RST_BYTE   8'h00

// ************************************************************
// mode encodings
// ************************************************************
`define CCPU_M_OFF      4'h0
`define CCPU_M_CMP_TGLR 4'h1
`define CCPU_M_CMP_TGL  4'h2
`define CCPU_M_CAP_FALL 4'h4
`define CCPU_M_CAP_RISE 4'h5
`define CCPU_M_CAP_R4   4'h6
`define CCPU_M_CAP_R16  4'h7
`define CCPU_M_CMP_SET  4'h8
`define CCPU_M_CMP_CLR  4'h9
`define CCPU_M_CMP_EVT  4'ha
`define CCPU_M_CMP_TRG  4'hb
`define CCPU_M_PWM      4'hc

// ************************************************************
// counts and period timer control fields
// ************************************************************
`define CCPU_PS4_LAST   4'h3
`define CCPU_PS16_LAST  4'hf
`define CCPU_PT_ON      2
`define CCPU_PT_PS      1:0
`define CCPU_PS_1TO1    2'h0
`define CCPU_PS_1TO4    2'h1
`define CCPU_PS_1TO16   2'h2
`define CCPU_DUTY_FULL  10'h3ff
`define CCPU_ONE16      16'h0001
`define CCPU_ONE8       8'h01
`define CCPU_ONE4       4'h1
`define CCPU_ONE2       2'h1
`define CCPU_ONE10      10'h001
`define CCPU_ZERO10     10'h000

`endif

// ---- tb/ccpu_src_model.sv ----
// capture sources, pin load and external tick that sit around the ccp unit
// assumes the bench sets source index and level just after rising edges
`timescale 1ns/1ps
module ccpu_src_model (
  // clock and bench control
  input  wire       mclk,
  input  wire [2:0] sel,
  input  wire       level,
  // pin as driven by the unit
  input  wire       pin_out,
  input  wire       pin_oe,
  // source lines and tick
  output wire [7:0] src,
  output reg        ext_tick
);
  reg  [1:0] div_reg;
  wire [7:0] one_hot;

  // only the chosen line moves; the others idle low
  assign one_hot = {7'h00, level} << sel;
  assign src[7:1] = one_hot[7:1];
  // pin line shows the real level, bench level on index 0 when released
  assign src[0] = pin_oe ? pin_out : one_hot[0];

  // tick from mclk, never every cycle, so the count stays synchronous
  initial div_reg = 2'h0;
  initial ext_tick = 1'b0;
  always @(posedge mclk) begin
    div_reg <= div_reg + 2'h1;
    ext_tick <= (div_reg == 2'h3);
  end
endmodule // ccpu_src_model

// ---- tb/ccpu_props.sv ----
// port checker for the ccp unit, bound onto its top module
// assumes one clock mclk and synchronous active-high srst
`timescale 1ns/1ps
module ccpu_props (
  // clock and reset
  input wire        mclk,
  input wire        srst,
  // register bus
  input wire [3:0]  avs_address,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire        avs_waitrequest,
  // context and outputs
  input wire        pin_direction_bit,
  input wire        trigger_source_sel,
  input wire        ccp_out,
  input wire        pin_out,
  input wire        pin_oe,
  input wire        ccp_event_flag,
  input wire        wake_req,
  input wire        conv_trigger
);
  // ************
  // properties
  // ************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // a long answer would let a held request be taken twice
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  property p_flag_sw;
    $fell(ccp_event_flag) |-> $past(avs_write) && ($past(avs_address) == 4'h3);
  endproperty
  a_flag_sw: assert property (p_flag_sw) else $error("flag cleared without a write");
  property p_trig_pulse;
    conv_trigger |=> !conv_trigger;
  endproperty
  a_trig_pulse: assert property (p_trig_pulse) else $error("trigger wider than one cycle");
  property p_trig_sel;
    conv_trigger |-> $past(trigger_source_sel);
  endproperty
  a_trig_sel: assert property (p_trig_sel) else $error("trigger while not selected");
  property p_trig_flag;
    conv_trigger |-> ##[0:1] ccp_event_flag;
  endproperty
  a_trig_flag: assert property (p_trig_flag) else $error("trigger without flag");
  property p_pin_follow;
    1'b1 |=> pin_out == $past(ccp_out);
  endproperty
  a_pin_follow: assert property (p_pin_follow) else $error("pin does not follow output");
  property p_pin_oe;
    1'b1 |=> pin_oe == !$past(pin_direction_bit);
  endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("pin drive against direction");
  property p_ctrl_zero;
    avs_write && avs_waitrequest && avs_address == 4'h0 && avs_writedata[7:0] == 8'h00 |-> ##[1:2] !ccp_out;
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero) else $error("output latch not forced low");
  property p_wake;
    wake_req |-> $past(ccp_event_flag);
  endproperty
  a_wake: assert property (p_wake) else $error("wake without flag");
endmodule // ccpu_props

bind ccpu_top ccpu_props u_props (
  .mclk(mclk), .srst(srst), .avs_address(avs_address), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .pin_direction_bit(pin_direction_bit), .trigger_source_sel(trigger_source_sel),
  .ccp_out(ccp_out), .pin_out(pin_out), .pin_oe(pin_oe), .ccp_event_flag(ccp_event_flag),
  .wake_req(wake_req), .conv_trigger(conv_trigger)
);

// ---- tb/test_capture_compare_pwm_unit.sv ----
// self-checking bench for the ccp unit: capture table, compare, pwm, sleep
// assumes the source model beside the unit and the bound port checker
`timescale 1ns/1ps
module test_capture_compare_pwm_unit;
  // ************
  // signals
  // ************
  reg         mclk, srst, avs_read, avs_write, sleep_mode, tb_ext_clocked;
  reg         trigger_source_sel, pin_direction_bit, src_level;
  reg  [3:0]  avs_address;
  reg  [31:0] avs_writedata;
  reg  [2:0]  src_sel;
  wire [31:0] avs_readdata;
  wire [7:0]  src;
  wire        avs_waitrequest, ext_tick, ccp_out, pin_out, pin_oe, ccp_event_flag, wake_req, conv_trigger;
  integer     fails, n_tests, r, p, k, cnt, n_trig;
  reg  [31:0] q;
  reg  [19:0] row;
  reg  [7:0]  c;
  reg  [23:0] pw;
  // capture rows: mode, source, rising edges, flag expected
  localparam [179:0] cap_tab = 180'h50011_41010_42021_63030_63010_64041_750f0_76101_57011;
  // compare rows: mode, trigger select in bit 1, output in bit 0
  localparam [47:0]  cmp_tab = 48'h83_90_23_a2_b2_13;
  // pwm rows: duty, high cycles out of 64
  localparam [71:0]  pwm_tab = 72'h0000_00_03ff_40_0008_20;

  ccpu_top dut (
    .mclk(mclk), .srst(srst), .clk_en(1'b1), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .capture_pin_input_select(src[0]), .comparator_one_synced(src[1]),
    .comparator_two_synced(src[2]), .pin_change_event(src[3]), .logic_cell_one_output(src[4]),
    .logic_cell_two_output(src[5]), .logic_cell_three_output(src[6]), .logic_cell_four_output(src[7]),
    .sleep_mode(sleep_mode), .tb_ext_tick(ext_tick), .tb_ext_clocked(tb_ext_clocked),
    .trigger_source_sel(trigger_source_sel), .pin_direction_bit(pin_direction_bit), .ccp_out(ccp_out),
    .pin_out(pin_out), .pin_oe(pin_oe), .ccp_event_flag(ccp_event_flag), .wake_req(wake_req),
    .conv_trigger(conv_trigger)
  );
  ccpu_src_model u_src (
    .mclk(mclk), .sel(src_sel), .level(src_level), .pin_out(pin_out), .pin_oe(pin_oe),
    .src(src), .ext_tick(ext_tick)
  );

  // ************
  // tasks
  // ************
  // request held until waitrequest is sampled low; one idle cycle after;
  // no local limit, a hang is ended by the watchdog
  task bus(input w, input [3:0] a, input [31:0] d, output [31:0] rd);
    begin
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0)
        @(posedge mclk);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge mclk);
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      if (fails == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask

  // ************
  // clock, watchdog and sequence
  // ************
  initial mclk = 1'b0;
  always #10 mclk = ~mclk;
  // the whole run needs well under this many cycles
  initial begin
    repeat (40000) @(posedge mclk);
    fails = fails + 1;
    report_and_stop;
  end
  initial begin
    {avs_read, avs_write, sleep_mode, tb_ext_clocked, trigger_source_sel, src_level} = 6'h00;
    {srst, pin_direction_bit, avs_address, avs_writedata, src_sel, fails, n_tests} = 0;
    srst = 1'b1;
    pin_direction_bit = 1'b1;
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    for (r = 0; r < 6; r = r + 1) begin
      bus(1'b0, r[3:0], 32'h0, q);
      chk(q, 32'h0);
    end
    bus(1'b1, 4'hd, 32'hffff, q);
    bus(1'b0, 4'hd, 32'h0, q);
    chk(q, 32'h0);
    // capture table; control cleared first so the edge prescaler restarts
    for (r = 0; r < 9; r = r + 1) begin
      row = cap_tab[179 - 20 * r -: 20];
      bus(1'b1, 4'h0, 32'h0, q);
      src_sel <= row[14:12];
      bus(1'b1, 4'h1, {28'h0, row[15:12]}, q);
      bus(1'b1, 4'h6, 32'hab00, q);
      bus(1'b1, 4'h0, {24'h0, 4'h8, row[19:16]}, q);
      bus(1'b1, 4'h3, 32'h0, q);
      for (p = 1; p <= row[11:4]; p = p + 1) begin
        src_level <= 1'b1;
        repeat (5) @(posedge mclk);
        if (p < row[11:4]) src_level <= 1'b0;
        if (p < row[11:4]) repeat (5) @(posedge mclk);
      end
      repeat (5) @(posedge mclk);
      chk(32'(ccp_event_flag), 32'(row[0]));
      bus(1'b0, 4'h2, 32'h0, q);
      if (row[0]) chk(32'(q[15:8]), 32'hab);
      if (r < 8) bus(1'b1, 4'h0, 32'h0, q);
      src_level <= 1'b0;
      repeat (5) @(posedge mclk);
    end
    // two captures with no read between: the later one stays
    src_level <= 1'b1;
    repeat (8) @(posedge mclk);
    src_level <= 1'b0;
    bus(1'b1, 4'h6, 32'h5e00, q);
    src_level <= 1'b1;
    repeat (8) @(posedge mclk);
    bus(1'b0, 4'h2, 32'h0, q);
    chk(32'(q[15:8]), 32'h5e);
    chk(32'(ccp_event_flag), 32'h1);
    bus(1'b1, 4'h0, 32'h0, q);
    src_level <= 1'b0;
    // compare actions, with and without trigger selection
    for (r = 0; r < 6; r = r + 1) begin
      c = cmp_tab[47 - 8 * r -: 8];
      trigger_source_sel <= c[1];
      bus(1'b1, 4'h0, 32'h0, q);
      bus(1'b1, 4'h6, 32'h0, q);
      bus(1'b1, 4'h2, 32'h0010, q);
      bus(1'b1, 4'h0, {24'h0, 4'h8, c[7:4]}, q);
      bus(1'b1, 4'h3, 32'h2, q);
      n_trig = 0;
      for (k = 0; k < 300 && ccp_event_flag !== 1'b1; k = k + 1) begin
        @(posedge mclk);
        n_trig = n_trig + conv_trigger;
      end
      repeat (4) @(posedge mclk) n_trig = n_trig + conv_trigger;
      chk(32'(ccp_event_flag), 32'h1);
      chk(32'(ccp_out), 32'(c[0]));
      chk(32'(wake_req), 32'h1);
      chk(n_trig, 32'(c[1]));
      bus(1'b0, 4'h6, 32'h0, q);
      if (c[7:4] == 4'hb) chk(32'(q[15:4]), 32'h0);
    end
    // pwm, period 16 cycles at 1:1, pin driven
    trigger_source_sel <= 1'b0;
    pin_direction_bit <= 1'b0;
    bus(1'b1, 4'h0, 32'h0, q);
    bus(1'b1, 4'h4, 32'h03, q);
    bus(1'b1, 4'h5, 32'h4, q);
    for (r = 0; r < 3; r = r + 1) begin
      pw = pwm_tab[71 - 24 * r -: 24];
      bus(1'b1, 4'h2, {16'h0, pw[23:8]}, q);
      bus(1'b1, 4'h0, 32'h8c, q);
      repeat (48) @(posedge mclk);
      cnt = 0;
      repeat (64) @(posedge mclk) cnt = cnt + ccp_out;
      chk(cnt, 32'(pw[7:0]));
    end
    bus(1'b0, 4'h7, 32'h0, q);
    chk(q, 32'h8);
    chk(32'(pin_oe), 32'h1);
    // sleep freezes the waveform at whatever level it had
    sleep_mode <= 1'b1;
    repeat (2) @(posedge mclk);
    p = ccp_out;
    cnt = 0;
    repeat (40) @(posedge mclk) cnt = cnt + (ccp_out !== p[0]);
    chk(cnt, 32'h0);
    // time base in sleep: held on the q-clock, counts the outside tick
    for (r = 0; r < 2; r = r + 1) begin
      tb_ext_clocked <= r[0];
      bus(1'b0, 4'h6, 32'h0, q);
      pw = q[23:0];
      repeat (17) @(posedge mclk);
      bus(1'b0, 4'h6, 32'h0, q);
      chk({16'h0, q[15:0] - pw[15:0]}, 32'h5 * r);
    end
    tb_ext_clocked <= 1'b0;
    sleep_mode <= 1'b0;
    report_and_stop;
  end
endmodule // test_capture_compare_pwm_unit
